// ---- inc/qtrim_pkg.sv ----
// Package for the Q channel offset and range trim register bank.
// Assumes a 16-bit register port with 4-bit register indices.
package qtrim_pkg;
	localparam int QTRIM_AW = 4;
	localparam int QTRIM_DW = 16;
	localparam logic [3:0] QTRIM_OFS_ADDR = 4'ha;
	localparam logic [3:0] QTRIM_FSR_ADDR = 4'hb;
	localparam logic [15:0] QTRIM_OFS_RESET = 16'h0000;
	localparam logic [15:0] QTRIM_FSR_RESET = 16'h4000;
	localparam int QTRIM_OFS_SIGN_POS = 12;
	localparam int QTRIM_OFS_MAG_W = 12;
	localparam int QTRIM_FSR_MAG_W = 15;
	localparam int QTRIM_FSR_MONO_W = 9;
	localparam logic [15:0] QTRIM_UNMAPPED_DATA = 16'h0000;
	// Offset full scale in uV: 45 mV over 4095 codes, about 11 uV a step
	localparam int QTRIM_OFS_FULL_UV = 45000;
	localparam int QTRIM_FSR_LOW_MV = 600;
	localparam int QTRIM_FSR_HIGH_MV = 980;
	localparam int QTRIM_FSR_NOM_MV = 790;
endpackage

// ---- sim/qtrim_regs_tb.sv ----
// Self-checking bench for the Q channel trim register bank.
// Assumes reads answer one cycle after the strobe and trims follow two cycles after a write.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module qtrim_regs_tb import qtrim_pkg::*;;
	logic sys_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, mode = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000, rdata;
	logic sgn;
	logic [11:0] mag;
	logic [14:0] rng;
	logic [8:0] crs;
	int n_mismatch = 0, checks = 0;
	logic [15:0] corner [4] = '{16'h0000, 16'h7fff, 16'h4000, 16'h4001};
	qtrim_regs dut (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .extended_control_mode(mode), .reg_rdata(rdata),
		.offset_sign_bit(sgn), .offset_magnitude_code(mag), .range_magnitude_code(rng),
		.range_coarse_code(crs));
	always #12.5 sys_clk = ~sys_clk;
	// Outside extended mode the analog trim never goes past the nominal code
	function automatic logic [14:0] exp_rng(input logic [15:0] v, input logic m);
		return (!m && v[14:0] > 15'h4000) ? 15'h4000 : v[14:0];
	endfunction
	// Called at a rising edge; a write that follows keeps the strobe up, so
	// no strobe is lowered and raised in one time step
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		reg_wr <= 1'b0;
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 `CHK(rdata, e)
		@(posedge sys_clk);
	endtask
	task automatic do_reset();
		nrst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rd(QTRIM_OFS_ADDR, QTRIM_OFS_RESET);
		rd(QTRIM_FSR_ADDR, QTRIM_FSR_RESET);
		`CHK({sgn, mag, rng, crs}, {1'b0, 12'h000, 15'h4000, 9'h100})
		$display("test reset done");
	endtask
	task automatic report_and_stop();
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		#50000;
		n_mismatch++;
		report_and_stop();
	end
	initial begin
		logic [15:0] d;
		logic [14:0] e;
		void'($urandom(33700));
		do_reset();
		for (int i = 0; i < 20; i++) begin
			d = (i == 0) ? 16'h1fff : (i == 1) ? 16'h1000 : 16'($urandom) & 16'h1fff;
			wr(QTRIM_OFS_ADDR, d);
			rd(QTRIM_OFS_ADDR, d);
			`CHK({sgn, mag}, d[12:0])
		end
		$display("test offset done");
		for (int i = 0; i < 24; i++) begin
			d = (i < 8) ? corner[i % 4] : 16'($urandom) & 16'h7fff;
			mode <= (i < 8) ? 1'(i / 4) : 1'($urandom);
			wr(QTRIM_FSR_ADDR, d);
			rd(QTRIM_FSR_ADDR, d);
			e = exp_rng(d, mode);
			`CHK(rng, e)
			`CHK(crs, e[14:6])
		end
		$display("test range done");
		wr(4'h3, 16'hbeef);
		rd(4'h3, QTRIM_UNMAPPED_DATA);
		rd(QTRIM_FSR_ADDR, d);
		@(posedge sys_clk);
		#1 `CHK(rdata, 16'h0000)
		$display("test unmapped done");
		do_reset();
		report_and_stop();
	end
endmodule
`default_nettype wire

// ---- src/qtrim_reg16.sv ----
// One 16-bit trim register with its own reset value.
// Assumes an active-low reset copy from the top module, applied asynchronously and released in step with clk.
`timescale 1ns/1ps
`default_nettype none
module qtrim_reg16 #(
	parameter logic [15:0] RESET_VALUE = 16'h0000
) (
	input wire logic clk, // system clock
	input wire logic rst_n, // released reset copy
	input wire logic wr_en, // load strobe
	input wire logic [15:0] wr_data, // value to load
	output logic [15:0] q // stored value
);
	logic [15:0] q_next;

	always_comb begin
		q_next = wr_en ? wr_data : q;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= RESET_VALUE;
		end else begin
			q <= q_next;
		end
	end
endmodule
`default_nettype wire

// ---- src/qtrim_regs.sv ----
// Q channel offset and full-scale range trim register bank.
// Assumes a plain register port driven synchronously to sys_clk; read data one cycle later.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module qtrim_regs
	import qtrim_pkg::*;
(
	input wire logic sys_clk, // 40 MHz clock
	input wire logic nrst, // async active-low reset
	input wire logic [3:0] reg_addr, // register index
	input wire logic [15:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	input wire logic extended_control_mode, // high when extended ranges are allowed
	output logic [15:0] reg_rdata, // read data, cycle after strobe
	output logic offset_sign_bit, // 1 = negative offset
	output logic [11:0] offset_magnitude_code, // offset magnitude
	output logic [14:0] range_magnitude_code, // range magnitude to analog trim
	output logic [8:0] range_coarse_code // monotonic upper range bits
);
	logic rst_meta_reg;
	logic rst_sync_reg;
	logic [15:0] ofs_q;
	logic [15:0] fsr_q;
	logic [15:0] rdata_next;
	logic [14:0] range_next;
	logic [15:0] reg_rdata_r;
	logic sign_next;
	logic [11:0] mag_next;
	logic [8:0] coarse_next;

	// Address decode is shared by the write enables and some of the checks; the read mux decodes the address in its own case
	function automatic logic hit_ofs(input logic [3:0] a);
		return a == QTRIM_OFS_ADDR;
	endfunction

	function automatic logic hit_fsr(input logic [3:0] a);
		return a == QTRIM_FSR_ADDR;
	endfunction

	// Without extended mode the range is capped at nominal, code 16384;
	// the register itself keeps the full written code
	function automatic logic [14:0] clamp_range(input logic [14:0] code, input logic ext);
		return (!ext && code > QTRIM_FSR_RESET[14:0]) ? QTRIM_FSR_RESET[14:0] : code;
	endfunction

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// Stored verbatim so reserved bits read back as written
	qtrim_reg16 #(.RESET_VALUE(QTRIM_OFS_RESET)) u_ofs (
		.clk(sys_clk),
		.rst_n(rst_sync_reg),
		.wr_en(reg_wr && hit_ofs(reg_addr)),
		.wr_data(reg_wdata),
		.q(ofs_q)
	);

	qtrim_reg16 #(.RESET_VALUE(QTRIM_FSR_RESET)) u_fsr (
		.clk(sys_clk),
		.rst_n(rst_sync_reg),
		.wr_en(reg_wr && hit_fsr(reg_addr)),
		.wr_data(reg_wdata),
		.q(fsr_q)
	);

	always_comb begin
		rdata_next = QTRIM_UNMAPPED_DATA;
		if (reg_rd) begin
			unique case (reg_addr)
				QTRIM_OFS_ADDR: rdata_next = ofs_q;
				QTRIM_FSR_ADDR: rdata_next = fsr_q;
				default: rdata_next = QTRIM_UNMAPPED_DATA;
			endcase
		end
		range_next = clamp_range(fsr_q[QTRIM_FSR_MAG_W-1:0], extended_control_mode);
		sign_next = ofs_q[QTRIM_OFS_SIGN_POS];
		mag_next = ofs_q[QTRIM_OFS_MAG_W-1:0];
		// Only these bits promise a monotonic step
		coarse_next = range_next[14 -: QTRIM_FSR_MONO_W];
	end

	always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			reg_rdata_r <= QTRIM_UNMAPPED_DATA;
			offset_sign_bit <= QTRIM_OFS_RESET[12];
			offset_magnitude_code <= QTRIM_OFS_RESET[11:0];
			range_magnitude_code <= QTRIM_FSR_RESET[14:0];
			range_coarse_code <= QTRIM_FSR_RESET[14:6];
		end else begin
			reg_rdata_r <= rdata_next;
			offset_sign_bit <= sign_next;
			offset_magnitude_code <= mag_next;
			range_magnitude_code <= range_next;
			range_coarse_code <= coarse_next;
		end
	end

	assign reg_rdata = reg_rdata_r;

	sequence s_ofs_write;
		reg_wr && reg_addr == QTRIM_OFS_ADDR;
	endsequence

	a_ofs_readback: assert property (@(posedge sys_clk) disable iff (!rst_sync_reg)
		s_ofs_write ##1 (reg_rd && reg_addr == QTRIM_OFS_ADDR && !reg_wr)
		|=> reg_rdata == $past(reg_wdata, 2))
		else $error("offset readback mismatch");
	a_fsr_store: assert property (@(posedge sys_clk) disable iff (!rst_sync_reg)
		(reg_wr && reg_addr == QTRIM_FSR_ADDR) |=> fsr_q == $past(reg_wdata))
		else $error("range store mismatch");
	a_hold_value: assert property (@(posedge sys_clk) disable iff (!rst_sync_reg)
		!reg_wr |=> $stable(ofs_q) && $stable(fsr_q))
		else $error("trim value changed without write");
	a_sign_follow: assert property (@(posedge sys_clk) disable iff (!rst_sync_reg)
		s_ofs_write |=> ##1 offset_sign_bit == $past(reg_wdata[12], 2))
		else $error("sign bit not applied");
	a_mag_follow: assert property (@(posedge sys_clk) disable iff (!rst_sync_reg)
		s_ofs_write |=> ##1 offset_magnitude_code == $past(reg_wdata[11:0], 2))
		else $error("offset magnitude not applied");
	a_ofs_reset: assert property (@(posedge sys_clk)
		$rose(rst_sync_reg) |-> ofs_q == 16'h0000 && !offset_sign_bit)
		else $error("offset reset value wrong");
	a_fsr_reset: assert property (@(posedge sys_clk)
		$rose(rst_sync_reg) |-> fsr_q == 16'h4000 && range_magnitude_code == 15'h4000)
		else $error("range reset value wrong");
	a_range_cap: assert property (@(posedge sys_clk) disable iff (!rst_sync_reg)
		!$past(extended_control_mode) |-> range_magnitude_code <= 15'h4000)
		else $error("range above nominal outside extended mode");
	a_range_ext: assert property (@(posedge sys_clk) disable iff (!rst_sync_reg)
		extended_control_mode |=> range_magnitude_code == $past(fsr_q[14:0]))
		else $error("range magnitude not passed in extended mode");
	a_coarse_bits: assert property (@(posedge sys_clk) disable iff (!rst_sync_reg)
		range_coarse_code == range_magnitude_code[14:6])
		else $error("coarse range bits wrong");
	a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (!rst_sync_reg)
		(reg_rd && reg_addr != QTRIM_OFS_ADDR && reg_addr != QTRIM_FSR_ADDR)
		|=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");

	sequence s_fsr_write;
		reg_wr && hit_fsr(reg_addr);
	endsequence

	sequence s_fsr_read;
		reg_rd && hit_fsr(reg_addr) && !reg_wr;
	endsequence

	// Storage and readback
	a_ofs_store: assert property (@(posedge sys_clk) disable iff (!rst_sync_reg)
		s_ofs_write |=> ofs_q == $past(reg_wdata))
		else $error("offset store mismatch");

	a_fsr_readback: assert property (@(posedge sys_clk) disable iff (!rst_sync_reg)
		s_fsr_write ##1 s_fsr_read |=> reg_rdata == $past(reg_wdata, 2))
		else $error("range readback mismatch");

	a_fsr_read_now: assert property (@(posedge sys_clk) disable iff (!rst_sync_reg)
		s_fsr_read |=> reg_rdata == $past(fsr_q))
		else $error("range read data wrong");

	a_ofs_read_now: assert property (@(posedge sys_clk) disable iff (!rst_sync_reg)
		(reg_rd && hit_ofs(reg_addr)) |=> reg_rdata == $past(ofs_q))
		else $error("offset read data wrong");

	a_rdata_idle: assert property (@(posedge sys_clk) disable iff (!rst_sync_reg)
		!reg_rd |=> reg_rdata == QTRIM_UNMAPPED_DATA)
		else $error("read data not idle");

	a_unmapped_wr: assert property (@(posedge sys_clk) disable iff (!rst_sync_reg)
		(reg_wr && !hit_ofs(reg_addr) && !hit_fsr(reg_addr)) |=> $stable(ofs_q) && $stable(fsr_q))
		else $error("unmapped write changed a trim");

	a_ofs_hold: assert property (@(posedge sys_clk) disable iff (!rst_sync_reg)
		!(reg_wr && hit_ofs(reg_addr)) |=> $stable(ofs_q))
		else $error("offset changed without its write");

	a_fsr_hold: assert property (@(posedge sys_clk) disable iff (!rst_sync_reg)
		!(reg_wr && hit_fsr(reg_addr)) |=> $stable(fsr_q))
		else $error("range changed without its write");

	// Range mapping to the analog trim
	a_range_clamp: assert property (@(posedge sys_clk) disable iff (!rst_sync_reg)
		(!extended_control_mode && fsr_q[14:0] > QTRIM_FSR_RESET[14:0])
		|=> range_magnitude_code == QTRIM_FSR_RESET[14:0])
		else $error("range not capped at nominal");

	a_range_low_same: assert property (@(posedge sys_clk) disable iff (!rst_sync_reg)
		(fsr_q[14:0] <= QTRIM_FSR_RESET[14:0]) |=> range_magnitude_code == $past(fsr_q[14:0]))
		else $error("low range differs between modes");

	a_range_follow: assert property (@(posedge sys_clk) disable iff (!rst_sync_reg)
		s_fsr_write ##1 extended_control_mode |=> range_magnitude_code == $past(reg_wdata[14:0], 2))
		else $error("range code not applied");

	// Reset values and reset release order
	a_coarse_reset: assert property (@(posedge sys_clk)
		$rose(rst_sync_reg) |-> range_coarse_code == QTRIM_FSR_RESET[14:6])
		else $error("coarse range reset value wrong");

	a_mag_reset: assert property (@(posedge sys_clk)
		$rose(rst_sync_reg) |-> offset_magnitude_code == QTRIM_OFS_RESET[11:0])
		else $error("offset magnitude reset value wrong");

	a_sync_order: assert property (@(posedge sys_clk)
		rst_sync_reg |-> rst_meta_reg)
		else $error("reset copy released out of order");
endmodule
`default_nettype wire
